// File: include/rms_consts.vh
// constants for the real-mode segment address unit
`ifndef RMS_CONSTS_VH
`define RMS_CONSTS_VH

// ****************************************
// user segment indices
// ****************************************
`define RMS_SEG_CODE 3'h0
`define RMS_SEG_DATA 3'h1
`define RMS_SEG_EXTRA 3'h2
`define RMS_SEG_EXTRA2 3'h3
`define RMS_SEG_EXTRA3 3'h4
`define RMS_SEG_STACK 3'h5
`define RMS_NUM_USER_SEG 6
`define RMS_NUM_SYS_SEG 4

// ****************************************
// system segment indices
// ****************************************
`define RMS_SYS_GLOBAL_TABLE 2'h0
`define RMS_SYS_LOCAL_TABLE 2'h1
`define RMS_SYS_VECTOR_TABLE 2'h2
`define RMS_SYS_TASK_POINTER 2'h3

// ****************************************
// widths and reset values
// ****************************************
`define RMS_SEL_W 16
`define RMS_REAL_ADDR_W 20
`define RMS_SEG_SHIFT 4
`define RMS_LIMIT_RST 32'h0000FFFF
`define RMS_ATTR_RST 12'h093
`define RMS_ATTR_BIG_BIT 10
`define RMS_SEL_RST 16'h0000

// ****************************************
// operating modes, one-hot, and request codes
// ****************************************
`define RMS_MODE_REAL 4'h1
`define RMS_MODE_PROT 4'h2
`define RMS_MODE_COMPAT 4'h4
`define RMS_MODE_LONG64 4'h8
`define RMS_REQ_REAL 2'h0
`define RMS_REQ_PROT 2'h1
`define RMS_REQ_COMPAT 2'h2
`define RMS_REQ_LONG64 2'h3

`endif

// File: logic/rms_seg_unit.v
// segment registers, mode tracking and linear address generation
`timescale 1ns/1ps
`default_nettype none
`include "rms_consts.vh"

module rms_seg_unit (
    input wire CLOCK_I,                 // core clock
    input wire RESET_I,                 // synchronous reset, active high
    input wire MODE_REQ_VALID_I,        // mode change request strobe
    input wire [1:0] MODE_REQ_I,        // requested mode code
    input wire LOAD_VALID_I,            // real-mode pop/copy selector load
    input wire [2:0] LOAD_SEG_I,        // user segment being loaded
    input wire [15:0] LOAD_SEL_I,       // new selector
    input wire FAR_VALID_I,             // real-mode intersegment transfer
    input wire [15:0] FAR_SEL_I,        // new code selector
    input wire DESC_VALID_I,            // protected descriptor load
    input wire [2:0] DESC_SEG_I,        // user segment for descriptor load
    input wire [15:0] DESC_SEL_I,       // selector for descriptor load
    input wire [31:0] DESC_BASE_I,      // descriptor base
    input wire [31:0] DESC_LIMIT_I,     // descriptor limit
    input wire [11:0] DESC_ATTR_I,      // descriptor attributes
    input wire SYS_WR_VALID_I,          // system segment register write
    input wire [1:0] SYS_WR_SEL_I,      // system register being written
    input wire [63:0] SYS_BASE_I,       // system register base
    input wire [31:0] SYS_LIMIT_I,      // system register limit
    input wire [1:0] SYS_RD_SEL_I,      // system register readout select
    input wire ACC_VALID_I,             // memory access request
    input wire [2:0] ACC_SEG_I,         // segment of the access
    input wire [63:0] ACC_EA_I,         // effective address
    output reg ACC_VALID_O,             // translated address valid pulse
    output reg [63:0] PHYS_ADDR_O,      // translated address
    output reg [3:0] MODE_O,            // one-hot current mode
    output reg TABLE_ACCESS_EN_O,       // descriptor/task tables usable
    output reg IGNORED_O,               // request refused pulse
    output reg [15:0] CODE_SEL_O,       // current code selector
    output reg [63:0] SYS_BASE_O,       // selected system register base
    output reg [31:0] SYS_LIMIT_O       // selected system register limit
);

    // ****************************************
    // operating mode
    // ****************************************
    localparam [3:0] MODE_REAL = `RMS_MODE_REAL;
    localparam [3:0] MODE_PROT = `RMS_MODE_PROT;
    localparam [3:0] MODE_COMPAT = `RMS_MODE_COMPAT;
    localparam [3:0] MODE_LONG64 = `RMS_MODE_LONG64;

    reg [3:0] mode_reg;
    reg [3:0] mode_next;
    reg mode_refused;

    always @* begin
        mode_next = mode_reg;
        mode_refused = 1'b0;
        if (MODE_REQ_VALID_I) begin
            case (mode_reg)
                MODE_REAL: begin
                    // only way out of real mode is protected mode
                    if (MODE_REQ_I == `RMS_REQ_PROT) begin
                        mode_next = MODE_PROT;
                    end else begin
                        mode_refused = 1'b1;
                    end
                end
                MODE_PROT: begin
                    case (MODE_REQ_I)
                        `RMS_REQ_REAL: mode_next = MODE_REAL;
                        `RMS_REQ_COMPAT: mode_next = MODE_COMPAT;
                        `RMS_REQ_LONG64: mode_next = MODE_LONG64;
                        default: mode_refused = 1'b1;
                    endcase
                end
                MODE_COMPAT, MODE_LONG64: begin
                    case (MODE_REQ_I)
                        `RMS_REQ_PROT: mode_next = MODE_PROT;
                        `RMS_REQ_COMPAT: mode_next = MODE_COMPAT;
                        `RMS_REQ_LONG64: mode_next = MODE_LONG64;
                        default: mode_refused = 1'b1;
                    endcase
                end
                default: begin
                    mode_next = MODE_REAL;
                end
            endcase
        end
    end

    always @(posedge CLOCK_I) begin
        if (RESET_I) begin
            mode_reg <= MODE_REAL;
        end else begin
            mode_reg <= mode_next;
        end
    end

    wire is_real = (mode_reg == MODE_REAL);

    // ****************************************
    // user segment registers
    // ****************************************
    wire [6*16-1:0] sel_next_flat;
    wire [6*32-1:0] base_next_flat;
    wire [6*12-1:0] attr_next_flat;
    wire [5:0] seg_hit;

    genvar g;
    generate
        for (g = 0; g < `RMS_NUM_USER_SEG; g = g + 1) begin : seg
            localparam integer IDX_INT = g;
            localparam [2:0] IDX = IDX_INT[2:0];
            reg [15:0] sel_reg;
            reg [31:0] base_reg;
            reg [31:0] limit_reg;
            reg [11:0] attr_reg;
            reg [15:0] sel_next;
            reg [31:0] base_next;
            reg [31:0] limit_next;
            reg [11:0] attr_next;
            reg hit;

            always @* begin
                sel_next = sel_reg;
                base_next = base_reg;
                limit_next = limit_reg;
                attr_next = attr_reg;
                hit = 1'b0;
                if (!is_real && DESC_VALID_I && DESC_SEG_I == IDX) begin
                    sel_next = DESC_SEL_I;
                    base_next = DESC_BASE_I;
                    limit_next = DESC_LIMIT_I;
                    attr_next = DESC_ATTR_I;
                    hit = 1'b1;
                end else if (is_real && LOAD_VALID_I && LOAD_SEG_I == IDX) begin
                    // limit and attributes stay as they are
                    sel_next = LOAD_SEL_I;
                    base_next = {12'h000, LOAD_SEL_I, 4'h0};
                    hit = 1'b1;
                end else if (is_real && FAR_VALID_I && IDX == `RMS_SEG_CODE) begin
                    sel_next = FAR_SEL_I;
                    base_next = {12'h000, FAR_SEL_I, 4'h0};
                    hit = 1'b1;
                end
            end

            always @(posedge CLOCK_I) begin
                if (RESET_I) begin
                    sel_reg <= `RMS_SEL_RST;
                    base_reg <= 32'h00000000;
                    limit_reg <= `RMS_LIMIT_RST;
                    attr_reg <= `RMS_ATTR_RST;
                end else begin
                    sel_reg <= sel_next;
                    base_reg <= base_next;
                    limit_reg <= limit_next;
                    attr_reg <= attr_next;
                end
            end

            assign sel_next_flat[g*16 +: 16] = sel_next;
            assign base_next_flat[g*32 +: 32] = base_next;
            assign attr_next_flat[g*12 +: 12] = attr_next;
            assign seg_hit[g] = hit;
        end
    endgenerate

    // ****************************************
    // system segment registers
    // ****************************************
    reg [63:0] sys_base_reg [0:3];
    reg [31:0] sys_limit_reg [0:3];
    integer k;

    always @(posedge CLOCK_I) begin
        if (RESET_I) begin
            for (k = 0; k < `RMS_NUM_SYS_SEG; k = k + 1) begin
                sys_base_reg[k] <= 64'h0000000000000000;
                sys_limit_reg[k] <= `RMS_LIMIT_RST;
            end
        end else if (SYS_WR_VALID_I) begin
            // kept in every mode, including 64-bit
            sys_base_reg[SYS_WR_SEL_I] <= SYS_BASE_I;
            sys_limit_reg[SYS_WR_SEL_I] <= SYS_LIMIT_I;
        end
    end

    // ****************************************
    // address generation, new base forwarded
    // ****************************************
    wire acc_seg_ok = (ACC_SEG_I < 3'h6);
    wire [2:0] acc_idx = acc_seg_ok ? ACC_SEG_I : 3'h0;
    wire [31:0] acc_base = base_next_flat[acc_idx*32 +: 32];
    wire [11:0] acc_attr = attr_next_flat[acc_idx*12 +: 12];
    wire acc_big = acc_attr[`RMS_ATTR_BIG_BIT];
    wire acc_fsgs = (ACC_SEG_I == `RMS_SEG_EXTRA2) || (ACC_SEG_I == `RMS_SEG_EXTRA3);

    reg [63:0] addr_next;
    reg [19:0] real_addr;
    reg [31:0] legacy_ea;

    always @* begin
        real_addr = acc_base[19:0] + {4'h0, ACC_EA_I[15:0]};
        legacy_ea = acc_big ? ACC_EA_I[31:0] : {16'h0000, ACC_EA_I[15:0]};
        addr_next = 64'h0000000000000000;
        case (mode_reg)
            MODE_REAL: addr_next = {44'h00000000000, real_addr};
            MODE_PROT, MODE_COMPAT: addr_next = {32'h00000000, acc_base + legacy_ea};
            MODE_LONG64: begin
                // flat space, only the two extra bases still apply
                addr_next = acc_fsgs ? ACC_EA_I + {32'h00000000, acc_base} : ACC_EA_I;
            end
            default: addr_next = 64'h0000000000000000;
        endcase
    end

    // ****************************************
    // refused requests
    // ****************************************
    // indices 6 and 7 alias slot 0 in the lookup, so refuse them first
    wire load_bad = LOAD_VALID_I && (!is_real || LOAD_SEG_I > `RMS_SEG_STACK
        || !seg_hit[acc_ok_idx(LOAD_SEG_I)]);
    wire far_bad = FAR_VALID_I && !is_real;
    wire desc_bad = DESC_VALID_I && (is_real || DESC_SEG_I > `RMS_SEG_STACK);
    wire acc_bad = ACC_VALID_I && !acc_seg_ok;

    function [2:0] acc_ok_idx;
        input [2:0] idx;
        begin
            acc_ok_idx = (idx < 3'h6) ? idx : 3'h0;
        end
    endfunction

    // ****************************************
    // output registers
    // ****************************************
    always @(posedge CLOCK_I) begin
        if (RESET_I) begin
            ACC_VALID_O <= 1'b0;
            PHYS_ADDR_O <= 64'h0000000000000000;
            MODE_O <= MODE_REAL;
            TABLE_ACCESS_EN_O <= 1'b0;
            IGNORED_O <= 1'b0;
            CODE_SEL_O <= `RMS_SEL_RST;
            SYS_BASE_O <= 64'h0000000000000000;
            SYS_LIMIT_O <= `RMS_LIMIT_RST;
        end else begin
            ACC_VALID_O <= ACC_VALID_I && acc_seg_ok;
            if (ACC_VALID_I && acc_seg_ok) begin
                PHYS_ADDR_O <= addr_next;
            end
            MODE_O <= mode_next;
            TABLE_ACCESS_EN_O <= (mode_next != MODE_REAL);
            IGNORED_O <= mode_refused || load_bad || far_bad || desc_bad || acc_bad;
            CODE_SEL_O <= sel_next_flat[15:0];
            SYS_BASE_O <= sys_base_reg[SYS_RD_SEL_I];
            SYS_LIMIT_O <= sys_limit_reg[SYS_RD_SEL_I];
        end
    end

endmodule // rms_seg_unit
`default_nettype wire

// File: test/rms_seg_monitor.sv
// port checks for the real-mode segment unit
`timescale 1ns/1ps
`default_nettype none
module rms_seg_monitor (
    input wire logic CLOCK_I, // core clock
    input wire logic RESET_I, // sync reset
    input wire logic MODE_REQ_VALID_I, // mode strobe
    input wire logic [1:0] MODE_REQ_I, // mode code
    input wire logic LOAD_VALID_I, // selector load
    input wire logic [2:0] LOAD_SEG_I, // load segment
    input wire logic [15:0] LOAD_SEL_I, // load selector
    input wire logic FAR_VALID_I, // far transfer
    input wire logic [15:0] FAR_SEL_I, // far selector
    input wire logic ACC_VALID_I, // access strobe
    input wire logic [2:0] ACC_SEG_I, // access segment
    input wire logic [63:0] ACC_EA_I, // effective address
    input wire logic ACC_VALID_O, // result pulse
    input wire logic [63:0] PHYS_ADDR_O, // result address
    input wire logic [3:0] MODE_O, // one-hot mode
    input wire logic TABLE_ACCESS_EN_O, // tables usable
    input wire logic IGNORED_O, // refusal pulse
    input wire logic [15:0] CODE_SEL_O // code selector
);
    default clocking @(posedge CLOCK_I); endclocking
    default disable iff (RESET_I);
    wire real_m = MODE_O == 4'h1;
    // ****************************************
    // assertions
    // ****************************************
    a_reset_real_mode: assert property ($fell(RESET_I) |-> real_m && !TABLE_ACCESS_EN_O)
        else $error("mode after reset not real");
    a_real_no_tables: assert property (real_m |-> !TABLE_ACCESS_EN_O)
        else $error("tables enabled in real mode");
    a_mode_refused: assert property (MODE_REQ_VALID_I && real_m && MODE_REQ_I != 2'h1 |=> real_m && IGNORED_O)
        else $error("illegal exit from real mode");
    a_access_latency: assert property (ACC_VALID_I && ACC_SEG_I <= 3'h5 |=> ACC_VALID_O)
        else $error("access result missing");
    a_bad_seg_refused: assert property (ACC_VALID_I && ACC_SEG_I > 3'h5 |=> !ACC_VALID_O && IGNORED_O)
        else $error("bad segment access taken");
    a_real_code_addr: assert property (ACC_VALID_I && ACC_SEG_I == 3'h0 && real_m && !LOAD_VALID_I
        && !FAR_VALID_I |=> PHYS_ADDR_O == {44'h0, 20'({$past(CODE_SEL_O), 4'h0}
        + {4'h0, $past(ACC_EA_I[15:0])})})
        else $error("real code address wrong");
    a_far_code_sel: assert property (FAR_VALID_I && real_m && !(LOAD_VALID_I && LOAD_SEG_I == 3'h0)
        |=> CODE_SEL_O == $past(FAR_SEL_I))
        else $error("far selector not stored");
    a_load_code_sel: assert property (LOAD_VALID_I && LOAD_SEG_I == 3'h0 && real_m
        |=> CODE_SEL_O == $past(LOAD_SEL_I))
        else $error("loaded selector not stored");
    a_flat_code_addr: assert property (ACC_VALID_I && ACC_SEG_I <= 3'h5 && ACC_SEG_I != 3'h3
        && ACC_SEG_I != 3'h4 && MODE_O == 4'h8
        |=> PHYS_ADDR_O == $past(ACC_EA_I))
        else $error("flat address not passed");
    a_far_refused: assert property (FAR_VALID_I && !real_m |=> IGNORED_O)
        else $error("far outside real mode taken");
    c_real_access: cover property (ACC_VALID_I && real_m);
    c_far: cover property (FAR_VALID_I && real_m);
    c_flat_access: cover property (ACC_VALID_I && MODE_O == 4'h8);
endmodule // rms_seg_monitor
`default_nettype wire

// File: test/rms_exec_model.sv
// access issuing side of the execution pipeline
`timescale 1ns/1ps
`default_nettype none
module rms_exec_model (
    input wire logic clk_i, // core clock
    input wire logic rst_i, // sync reset
    input wire logic go_i, // queue one access
    input wire logic [3:0] dly_i, // issue delay
    input wire logic [2:0] seg_i, // access segment
    input wire logic [63:0] ea_i, // effective address
    output logic acc_valid_o, // access strobe
    output logic [2:0] acc_seg_o, // access segment
    output logic [63:0] acc_ea_o // effective address
);
    logic pend_reg;
    logic [3:0] cnt_reg;
    logic [2:0] seg_reg;
    logic [63:0] ea_reg;
    // address scrambled while idle
    always @(posedge clk_i) begin
        if (rst_i) begin
            pend_reg <= 1'b0;
            acc_valid_o <= 1'b0;
            acc_ea_o <= 64'h0;
            acc_seg_o <= 3'h0;
        end else if (go_i) begin
            pend_reg <= 1'b1;
            cnt_reg <= dly_i;
            seg_reg <= seg_i;
            ea_reg <= ea_i;
            acc_valid_o <= 1'b0;
            acc_ea_o <= ~acc_ea_o;
            acc_seg_o <= ~acc_seg_o;
        end else if (pend_reg && cnt_reg == 4'h0) begin
            pend_reg <= 1'b0;
            acc_valid_o <= 1'b1;
            acc_seg_o <= seg_reg;
            acc_ea_o <= ea_reg;
        end else begin
            acc_valid_o <= 1'b0;
            acc_ea_o <= ~acc_ea_o;
            acc_seg_o <= ~acc_seg_o;
            if (pend_reg) begin
                cnt_reg <= cnt_reg - 4'h1;
            end
        end
    end
endmodule // rms_exec_model
`default_nettype wire

// File: test/test_real_mode_segment_addressing.sv
// bench for the real-mode segment unit
`timescale 1ns/1ps
`default_nettype none
module test_real_mode_segment_addressing;
    logic CLOCK_I = 1'b0, RESET_I = 1'b1, go = 1'b0;
    logic [4:0] vld = 5'h0;
    logic [15:0] pa = 16'h0, sl;
    logic [2:0] ps = 3'h0, go_seg = 3'h0, sg;
    logic [1:0] SYS_RD_SEL_I = 2'h0;
    logic [3:0] go_dly = 4'h0;
    logic [11:0] DESC_ATTR_I = 12'h0;
    logic [31:0] DESC_BASE_I = 32'h0, DESC_LIMIT_I = 32'h0, SYS_LIMIT_I = 32'h0, seed = 32'h102D;
    logic [63:0] SYS_BASE_I = 64'h0, go_ea = 64'h0, r64;
    wire MODE_REQ_VALID_I = vld[0], LOAD_VALID_I = vld[1], FAR_VALID_I = vld[2];
    wire DESC_VALID_I = vld[3], SYS_WR_VALID_I = vld[4];
    wire [15:0] LOAD_SEL_I = pa, FAR_SEL_I = pa, DESC_SEL_I = pa;
    wire [2:0] LOAD_SEG_I = ps, DESC_SEG_I = ps, ACC_SEG_I;
    wire [1:0] MODE_REQ_I = pa[1:0], SYS_WR_SEL_I = ps[1:0];
    wire ACC_VALID_I, ACC_VALID_O, TABLE_ACCESS_EN_O, IGNORED_O;
    wire [63:0] ACC_EA_I, PHYS_ADDR_O, SYS_BASE_O;
    wire [3:0] MODE_O;
    wire [15:0] CODE_SEL_O;
    wire [31:0] SYS_LIMIT_O;
    int err_total = 0, checks_done = 0, i, n;
    rms_seg_unit dut_u (
        .CLOCK_I(CLOCK_I), .RESET_I(RESET_I),
        .MODE_REQ_VALID_I(MODE_REQ_VALID_I), .MODE_REQ_I(MODE_REQ_I),
        .LOAD_VALID_I(LOAD_VALID_I), .LOAD_SEG_I(LOAD_SEG_I), .LOAD_SEL_I(LOAD_SEL_I),
        .FAR_VALID_I(FAR_VALID_I), .FAR_SEL_I(FAR_SEL_I),
        .DESC_VALID_I(DESC_VALID_I), .DESC_SEG_I(DESC_SEG_I), .DESC_SEL_I(DESC_SEL_I),
        .DESC_BASE_I(DESC_BASE_I), .DESC_LIMIT_I(DESC_LIMIT_I), .DESC_ATTR_I(DESC_ATTR_I),
        .SYS_WR_VALID_I(SYS_WR_VALID_I), .SYS_WR_SEL_I(SYS_WR_SEL_I),
        .SYS_BASE_I(SYS_BASE_I), .SYS_LIMIT_I(SYS_LIMIT_I), .SYS_RD_SEL_I(SYS_RD_SEL_I),
        .ACC_VALID_I(ACC_VALID_I), .ACC_SEG_I(ACC_SEG_I), .ACC_EA_I(ACC_EA_I),
        .ACC_VALID_O(ACC_VALID_O), .PHYS_ADDR_O(PHYS_ADDR_O), .MODE_O(MODE_O),
        .TABLE_ACCESS_EN_O(TABLE_ACCESS_EN_O), .IGNORED_O(IGNORED_O),
        .CODE_SEL_O(CODE_SEL_O), .SYS_BASE_O(SYS_BASE_O), .SYS_LIMIT_O(SYS_LIMIT_O));
    rms_exec_model exec_u (.clk_i(CLOCK_I), .rst_i(RESET_I), .go_i(go), .dly_i(go_dly),
        .seg_i(go_seg), .ea_i(go_ea), .acc_valid_o(ACC_VALID_I), .acc_seg_o(ACC_SEG_I),
        .acc_ea_o(ACC_EA_I));
    // ****************************************
    // helpers
    // ****************************************
    task report_and_stop;
        if (err_total == 0 && checks_done > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    task chk(input string nm, input logic [63:0] e, input logic [63:0] g);
        checks_done++;
        if (g !== e) begin
            err_total++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask
    function logic [31:0] rnd;
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    function logic [63:0] real_exp(input logic [15:0] s, input logic [63:0] ea);
        return {44'h0, 20'({s, 4'h0} + {4'h0, ea[15:0]})};
    endfunction
    // kinds: 0 mode, 1 load, 2 far, 3 descriptor, 4 system write
    task pulse(input int k, input logic [15:0] a, input logic [2:0] s);
        @(posedge CLOCK_I);
        vld <= 5'(5'h1 << k);
        pa <= a;
        ps <= s;
        @(posedge CLOCK_I);
        vld <= 5'h0;
        #1;
    endtask
    task access(input logic [2:0] s, input logic [63:0] ea, input logic [63:0] e);
        @(posedge CLOCK_I);
        go <= 1'b1;
        go_seg <= s;
        go_ea <= ea;
        go_dly <= 4'(rnd() % 4);
        @(posedge CLOCK_I);
        go <= 1'b0;
        #1;
        for (i = 0; i < 20 && (ACC_VALID_O | IGNORED_O) !== 1'b1; i++) @(posedge CLOCK_I) #1;
        if (i == 20) begin
            err_total++;
            report_and_stop();
        end else begin
            chk("acc_valid", 64'(s <= 3'h5), 64'(ACC_VALID_O));
            if (s <= 3'h5) chk("phys_addr", e, PHYS_ADDR_O);
        end
    endtask
    // ****************************************
    // scenarios
    // ****************************************
    initial forever #4 CLOCK_I = ~CLOCK_I;
    initial begin
        repeat (10) @(posedge CLOCK_I);
        RESET_I <= 1'b0;
        @(posedge CLOCK_I) #1;
        chk("mode", 64'h1, 64'(MODE_O));
        chk("tables", 64'h0, 64'(TABLE_ACCESS_EN_O));
        chk("sys_limit", 64'hFFFF, 64'(SYS_LIMIT_O));
        pulse(2, 16'hFFFF, 3'h0);
        chk("code_sel", 64'hFFFF, 64'(CODE_SEL_O));
        access(3'h0, 64'h20, 64'h10);
        for (n = 0; n < 40; n++) begin
            sl = 16'(rnd());
            sg = 3'(rnd() % 6);
            r64 = {rnd(), rnd()};
            pulse(1, sl, sg);
            access(sg, r64, real_exp(sl, r64));
        end
        access(3'h7, 64'h0, 64'h0);
        pulse(3, 16'h8, 3'h2);
        chk("ignored", 64'h1, 64'(IGNORED_O));
        pulse(1, 16'hFFFF, 3'h1);
        pulse(0, 16'h2, 3'h0);
        chk("ignored", 64'h1, 64'(IGNORED_O));
        pulse(0, 16'h1, 3'h0);
        chk("mode", 64'h2, 64'(MODE_O));
        chk("tables", 64'h1, 64'(TABLE_ACCESS_EN_O));
        pulse(1, 16'h1234, 3'h1);
        chk("ignored", 64'h1, 64'(IGNORED_O));
        access(3'h1, 64'h1234_5678_9ABC_DEF0, 64'h10DEE0);
        pulse(0, 16'h3, 3'h0);
        chk("mode", 64'h8, 64'(MODE_O));
        r64 = {rnd(), rnd()};
        access(3'h1, r64, r64);
        DESC_BASE_I <= rnd();
        pulse(3, 16'h10, 3'h3);
        access(3'h3, r64, r64 + {32'h0, DESC_BASE_I});
        pulse(2, 16'h5555, 3'h0);
        chk("ignored", 64'h1, 64'(IGNORED_O));
        SYS_BASE_I <= r64;
        SYS_LIMIT_I <= ~r64[31:0];
        SYS_RD_SEL_I <= 2'h3;
        pulse(4, 16'h0, 3'h3);
        @(posedge CLOCK_I) #1;
        chk("sys_base", r64, SYS_BASE_O);
        chk("sys_limit", {32'h0, ~r64[31:0]}, 64'(SYS_LIMIT_O));
        pulse(0, 16'h2, 3'h0);
        chk("mode", 64'h4, 64'(MODE_O));
        DESC_BASE_I <= rnd();
        DESC_ATTR_I <= 12'h493;
        DESC_LIMIT_I <= 32'hFFFFFFFF;
        pulse(3, 16'h8, 3'h2);
        access(3'h2, r64, {32'h0, DESC_BASE_I + r64[31:0]});
        report_and_stop();
    end
endmodule // test_real_mode_segment_addressing
bind rms_seg_unit rms_seg_monitor mon_u (
    .CLOCK_I(CLOCK_I), .RESET_I(RESET_I),
    .MODE_REQ_VALID_I(MODE_REQ_VALID_I), .MODE_REQ_I(MODE_REQ_I),
    .LOAD_VALID_I(LOAD_VALID_I), .LOAD_SEG_I(LOAD_SEG_I), .LOAD_SEL_I(LOAD_SEL_I),
    .FAR_VALID_I(FAR_VALID_I), .FAR_SEL_I(FAR_SEL_I),
    .ACC_VALID_I(ACC_VALID_I), .ACC_SEG_I(ACC_SEG_I), .ACC_EA_I(ACC_EA_I),
    .ACC_VALID_O(ACC_VALID_O), .PHYS_ADDR_O(PHYS_ADDR_O), .MODE_O(MODE_O),
    .TABLE_ACCESS_EN_O(TABLE_ACCESS_EN_O), .IGNORED_O(IGNORED_O), .CODE_SEL_O(CODE_SEL_O));
`default_nettype wire
